/* File: hdl/dsl_defines.vh */
`ifndef DSL_DEFINES_VH
`define DSL_DEFINES_VH
// =====================================================================
// clock and timing
`define DSL_CLK_HZ 250000000
`define DSL_CYC_PER_MS (`DSL_CLK_HZ / 1000)
`define DSL_T_FLICKER_MS 50
`define DSL_T_FLASH_MS 200
`define DSL_T_LONG_OFF_MS 1000
// =====================================================================
// register byte offsets
`define DSL_OFF_CTRL 12'h000
`define DSL_OFF_STATUS 12'h004
`define DSL_OFF_IRQ_STAT 12'h008
`define DSL_OFF_IRQ_MASK 12'h00C
`define DSL_OFF_ALIAS 12'h010
// =====================================================================
// ctrl fields
`define DSL_CTRL_ENABLE 0
`define DSL_CTRL_FAULT 1
`define DSL_CTRL_RESET 32'h0000_0000
// irq status bits
`define DSL_IRQ_STATE 0
`define DSL_IRQ_ERROR 1
`define DSL_IRQ_FAULT 2
`define DSL_IRQ_W 3
// slave states
`define DSL_ST_INIT 4'h1
`define DSL_ST_PREOP 4'h2
`define DSL_ST_BOOT 4'h3
`define DSL_ST_SAFEOP 4'h4
`define DSL_ST_OP 4'h8
// pattern codes
`define DSL_PAT_OFF 3'd0
`define DSL_PAT_ON 3'd1
`define DSL_PAT_BLINK 3'd2
`define DSL_PAT_SINGLE 3'd3
`define DSL_PAT_DOUBLE 3'd4
`define DSL_PAT_FLICKER 3'd5
`endif

/* File: hdl/dsl_pattern_gen.v */
`timescale 1ns/1ps
`include "dsl_defines.vh"
// =====================================================================
// pattern generator driven by the shared millisecond tick
module dsl_pattern_gen (
	input wire clk,
	input wire rstn,
	input wire ms_tick,
	input wire [2:0] pattern,
	output reg led
);
	reg [10:0] ms_reg; // position within the pattern period
	reg [2:0] pat_reg; // last pattern, to detect a change
	reg [10:0] period; // length of the current pattern
	reg lit; // combinational lamp value
	// =================================================================
	// period and on-window per pattern
	always @* begin
		period = 11'd1;
		lit = 1'b0;
		case (pattern)
			`DSL_PAT_ON: begin
				lit = 1'b1;
			end
			`DSL_PAT_BLINK: begin
				period = 11'd400;
				lit = ms_reg < `DSL_T_FLASH_MS;
			end
			`DSL_PAT_SINGLE: begin
				period = 11'd1200;
				lit = ms_reg < `DSL_T_FLASH_MS;
			end
			`DSL_PAT_DOUBLE: begin
				period = 11'd1600;
				lit = (ms_reg < `DSL_T_FLASH_MS) || (ms_reg >= 2 * `DSL_T_FLASH_MS && ms_reg < 3 * `DSL_T_FLASH_MS);
			end
			`DSL_PAT_FLICKER: begin
				period = 11'd100;
				lit = ms_reg < `DSL_T_FLICKER_MS;
			end
			default: begin
				lit = 1'b0;
			end
		endcase
	end
	// =================================================================
	// millisecond position, restarted on pattern change
	always @(posedge clk) begin
		if (!rstn) begin
			ms_reg <= 11'd0;
			pat_reg <= `DSL_PAT_OFF;
			led <= 1'b0;
		end else begin
			pat_reg <= pattern;
			if (pattern != pat_reg) begin
				ms_reg <= 11'd0;
			end else if (ms_tick) begin
				ms_reg <= (ms_reg + 11'd1 >= period) ? 11'd0 : ms_reg + 11'd1;
			end
			led <= (pattern != pat_reg) ? (pattern != `DSL_PAT_OFF) : lit;
		end
	end
endmodule

/* File: hdl/dsl_led_top.v */
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dsl_defines.vh"
module dsl_led_top #(
	parameter CYC_PER_MS = `DSL_CYC_PER_MS,
	parameter NPORT = 2
) (
	input wire clk,
	input wire rstn,
	// raw status from drive and slave controller
	input wire logic_supply_ok,
	input wire dc_bus_ok,
	input wire [NPORT-1:0] link_valid,
	input wire [NPORT-1:0] link_traffic,
	input wire [3:0] al_state,
	input wire al_change,
	input wire booting,
	input wire fw_download,
	input wire pdi_wd_timeout,
	input wire config_error,
	input wire app_wd_timeout,
	input wire [15:0] net_alias_data,
	input wire net_alias_we,
	// axi4-lite slave
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// leds
	output reg bridge_green_led,
	output reg bridge_red_led,
	output reg logic_supply_led,
	output reg [NPORT-1:0] port_link_traffic_led,
	output wire slave_state_led,
	output wire error_led,
	output reg [15:0] station_alias,
	output reg irq
);
	// =================================================================
	// input synchronisers, two stages, first stage read only by second
	// alias data rides on top so it arrives together with its write strobe
	localparam SW = 25 + 2 * NPORT;
	wire [SW-1:0] raw_in;
	reg [SW-1:0] sync1_reg;
	reg [SW-1:0] sync2_reg;
	reg [3:0] st_s1_reg; // al_state stage one
	reg [3:0] st_s2_reg; // al_state stage two
	reg [3:0] st_s3_reg; // al_state one cycle later, for the settle test
	reg [3:0] st_reg; // settled state word; bits may land in different cycles
	assign raw_in = {net_alias_data, logic_supply_ok, dc_bus_ok, link_valid, link_traffic, al_change,
		booting, fw_download, pdi_wd_timeout, config_error, app_wd_timeout, net_alias_we};
	always @(posedge clk) begin
		if (!rstn) begin
			sync1_reg <= {SW{1'b0}};
			sync2_reg <= {SW{1'b0}};
			st_s1_reg <= 4'h0;
			st_s2_reg <= 4'h0;
			st_s3_reg <= 4'h0;
			st_reg <= 4'h0;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
			st_s1_reg <= al_state;
			st_s2_reg <= st_s1_reg;
			st_s3_reg <= st_s2_reg;
			// take the word only once two samples agree, so no mixed code is shown
			if (st_s2_reg == st_s3_reg) begin
				st_reg <= st_s2_reg;
			end
		end
	end
	wire [15:0] s_alias_data = sync2_reg[SW-1:SW-16];
	wire s_alias_we = sync2_reg[0];
	wire s_app_wd = sync2_reg[1];
	wire s_cfg_err = sync2_reg[2];
	wire s_pdi_wd = sync2_reg[3];
	wire s_fwdl = sync2_reg[4];
	wire s_boot = sync2_reg[5];
	wire s_change = sync2_reg[6];
	wire [NPORT-1:0] s_traffic = sync2_reg[6+NPORT:7];
	wire [NPORT-1:0] s_link = sync2_reg[6+2*NPORT:7+NPORT];
	wire s_dc_bus = sync2_reg[7+2*NPORT];
	wire s_logic = sync2_reg[8+2*NPORT];
	// =================================================================
	// shared millisecond timebase
	reg [31:0] tb_reg; // cycle counter within one millisecond
	reg ms_tick_reg; // one-cycle pulse every millisecond
	always @(posedge clk) begin
		if (!rstn) begin
			tb_reg <= 32'h0000_0000;
			ms_tick_reg <= 1'b0;
		end else if (tb_reg == CYC_PER_MS - 1) begin
			tb_reg <= 32'h0000_0000;
			ms_tick_reg <= 1'b1;
		end else begin
			tb_reg <= tb_reg + 32'h0000_0001;
			ms_tick_reg <= 1'b0;
		end
	end
	// =================================================================
	// registers
	reg [31:0] ctrl_reg; // enable and fault command bits
	reg [`DSL_IRQ_W-1:0] irq_stat_reg; // sticky events
	reg [`DSL_IRQ_W-1:0] irq_mask_reg; // one enables the event
	reg [2:0] state_pat_reg; // selected slave state pattern
	reg [2:0] err_pat_reg; // selected error pattern
	reg [5:0] flick_cnt_reg; // ms count within one flicker half period
	reg flick_reg; // free running flicker phase for link traffic
	wire drv_enable = ctrl_reg[`DSL_CTRL_ENABLE];
	wire drv_fault = ctrl_reg[`DSL_CTRL_FAULT];
	// =================================================================
	// pattern selection for state and error leds
	reg [2:0] state_pat_next;
	reg [2:0] err_pat_next;
	always @* begin
		// booting, bootstrap and download override the state
		if (s_boot || s_fwdl || st_reg == `DSL_ST_BOOT) begin
			state_pat_next = `DSL_PAT_FLICKER;
		end else begin
			case (st_reg)
				`DSL_ST_OP: state_pat_next = `DSL_PAT_ON;
				`DSL_ST_PREOP: state_pat_next = `DSL_PAT_BLINK;
				`DSL_ST_SAFEOP: state_pat_next = `DSL_PAT_SINGLE;
				default: state_pat_next = `DSL_PAT_OFF;
			endcase
		end
		// the most severe fault shown first; no error keeps the led dark
		if (s_pdi_wd) begin
			err_pat_next = `DSL_PAT_ON;
		end else if (s_app_wd) begin
			err_pat_next = `DSL_PAT_DOUBLE;
		end else if (s_cfg_err) begin
			err_pat_next = `DSL_PAT_BLINK;
		end else if (s_change && st_reg == `DSL_ST_INIT) begin
			err_pat_next = `DSL_PAT_FLICKER;
		end else if (s_change) begin
			err_pat_next = `DSL_PAT_SINGLE;
		end else begin
			err_pat_next = `DSL_PAT_OFF;
		end
	end
	// =================================================================
	// steady leds and pattern latches
	always @(posedge clk) begin
		if (!rstn) begin
			bridge_green_led <= 1'b0;
			bridge_red_led <= 1'b0;
			logic_supply_led <= 1'b0;
			port_link_traffic_led <= {NPORT{1'b0}};
			state_pat_reg <= `DSL_PAT_OFF;
			err_pat_reg <= `DSL_PAT_OFF;
		end else begin
			bridge_red_led <= drv_fault;
			bridge_green_led <= !drv_fault && s_dc_bus && drv_enable;
			logic_supply_led <= s_logic;
			// traffic flickers with the shared 50 ms phase
			port_link_traffic_led <= s_link & (~s_traffic | {NPORT{flick_reg}});
			state_pat_reg <= state_pat_next;
			err_pat_reg <= err_pat_next;
		end
	end
	// =================================================================
	// free flicker phase for link traffic
	always @(posedge clk) begin
		if (!rstn) begin
			flick_cnt_reg <= 6'd0;
			flick_reg <= 1'b0;
		end else if (ms_tick_reg) begin
			if (flick_cnt_reg == `DSL_T_FLICKER_MS - 1) begin
				flick_cnt_reg <= 6'd0;
				flick_reg <= !flick_reg;
			end else begin
				flick_cnt_reg <= flick_cnt_reg + 6'd1;
			end
		end
	end
	// =================================================================
	// pattern generators share the one timebase
	dsl_pattern_gen u_state_gen (
		.clk(clk),
		.rstn(rstn),
		.ms_tick(ms_tick_reg),
		.pattern(state_pat_reg),
		.led(slave_state_led)
	);
	dsl_pattern_gen u_err_gen (
		.clk(clk),
		.rstn(rstn),
		.ms_tick(ms_tick_reg),
		.pattern(err_pat_reg),
		.led(error_led)
	);
	// =================================================================
	// axi4-lite write path; address and data taken in either order
	reg aw_have_reg;
	reg w_have_reg;
	reg [11:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	reg [`DSL_IRQ_W-1:0] ev;
	reg [`DSL_IRQ_W-1:0] w1c;
	// event sources: pattern changes and bridge fault rising
	always @* begin
		ev = {drv_fault && !bridge_red_led, err_pat_next != err_pat_reg,
			state_pat_next != state_pat_reg};
		w1c = {`DSL_IRQ_W{1'b0}};
		if (do_write && aw_addr_reg == `DSL_OFF_IRQ_STAT && w_strb_reg[0]) begin
			w1c = w_data_reg[`DSL_IRQ_W-1:0];
		end
	end
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] strb;
		integer i;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
			end
		end
	endfunction
	wire [31:0] alias_merged = merge({16'h0000, station_alias}, w_data_reg, w_strb_reg);
	always @(posedge clk) begin
		if (!rstn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			ctrl_reg <= `DSL_CTRL_RESET;
			irq_stat_reg <= {`DSL_IRQ_W{1'b0}};
			irq_mask_reg <= {`DSL_IRQ_W{1'b0}};
			station_alias <= 16'h0000;
			irq <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready;
			s_axi_wready <= !w_have_reg && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (aw_addr_reg)
					`DSL_OFF_CTRL: ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0003;
					`DSL_OFF_IRQ_MASK: begin
						if (w_strb_reg[0]) irq_mask_reg <= w_data_reg[`DSL_IRQ_W-1:0];
					end
					`DSL_OFF_ALIAS: station_alias <= alias_merged[15:0];
					`DSL_OFF_IRQ_STAT, `DSL_OFF_STATUS: s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10; // unmapped: slave error
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// network write of the alias; the software write wins a tie
			if (s_alias_we && !(do_write && aw_addr_reg == `DSL_OFF_ALIAS)) begin
				station_alias <= s_alias_data;
			end
			// set wins over a simultaneous clear
			irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end
	// =================================================================
	// axi4-lite read path
	reg [31:0] rd_val;
	always @* begin
		case (s_axi_araddr)
			`DSL_OFF_CTRL: rd_val = ctrl_reg;
			`DSL_OFF_STATUS: rd_val = {20'h0_0000, slave_state_led, error_led, err_pat_reg, state_pat_reg, st_reg};
			`DSL_OFF_IRQ_STAT: rd_val = {29'h0, irq_stat_reg};
			`DSL_OFF_IRQ_MASK: rd_val = {29'h0, irq_mask_reg};
			`DSL_OFF_ALIAS: rd_val = {16'h0000, station_alias};
			default: rd_val = 32'h0000_0000;
		endcase
	end
	always @(posedge clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				case (s_axi_araddr)
					`DSL_OFF_CTRL, `DSL_OFF_STATUS, `DSL_OFF_IRQ_STAT, `DSL_OFF_IRQ_MASK,
					`DSL_OFF_ALIAS: s_axi_rresp <= 2'b00;
					default: s_axi_rresp <= 2'b10;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

/* File: test/dsl_led_top_assertions.sv */
`timescale 1ns/1ps
`include "dsl_defines.vh"
// ====
// port checker, every input reaches its led within 6 cycles, inside the 8-cycle hold
module dsl_chk #(
	parameter NPORT = 2
) (
	input wire clk,
	input wire rstn,
	input wire logic_supply_ok,
	input wire dc_bus_ok,
	input wire [NPORT-1:0] link_valid,
	input wire [NPORT-1:0] link_traffic,
	input wire [3:0] al_state,
	input wire al_change,
	input wire booting,
	input wire fw_download,
	input wire pdi_wd_timeout,
	input wire config_error,
	input wire app_wd_timeout,
	input wire bridge_green_led,
	input wire bridge_red_led,
	input wire logic_supply_led,
	input wire [NPORT-1:0] port_link_traffic_led,
	input wire slave_state_led,
	input wire error_led
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// no error source at all
	wire quiet = !(pdi_wd_timeout | app_wd_timeout | config_error | al_change);
	// no boot flicker override
	wire plain = !booting && !fw_download;
	bridge_excl_a: assert property (!(bridge_green_led && bridge_red_led))
		else $error("bridge both lit");
	bus_off_a: assert property (!dc_bus_ok [*8] |-> !bridge_green_led)
		else $error("green without bus");
	supply_on_a: assert property (logic_supply_ok [*8] |-> logic_supply_led)
		else $error("supply led dark");
	link_on_a: assert property (link_valid[0] && !link_traffic[0] [*8] |-> port_link_traffic_led[0])
		else $error("idle link dark");
	link_off_a: assert property (!link_valid[0] [*8] |-> !port_link_traffic_led[0])
		else $error("bad link lit");
	op_steady_a: assert property (plain && al_state == `DSL_ST_OP [*8] |-> slave_state_led)
		else $error("op led dark");
	init_dark_a: assert property (plain && al_state == `DSL_ST_INIT [*8] |-> !slave_state_led)
		else $error("init led lit");
	pdi_steady_a: assert property (pdi_wd_timeout [*8] |-> error_led)
		else $error("pdi led dark");
	err_dark_a: assert property (quiet [*8] |-> !error_led)
		else $error("error led lit");
endmodule
bind dsl_led_top dsl_chk #(.NPORT(NPORT)) u_chk (
	.clk(clk), .rstn(rstn), .logic_supply_ok(logic_supply_ok), .dc_bus_ok(dc_bus_ok),
	.link_valid(link_valid), .link_traffic(link_traffic), .al_state(al_state), .al_change(al_change),
	.booting(booting), .fw_download(fw_download), .pdi_wd_timeout(pdi_wd_timeout),
	.config_error(config_error), .app_wd_timeout(app_wd_timeout), .bridge_green_led(bridge_green_led),
	.bridge_red_led(bridge_red_led), .logic_supply_led(logic_supply_led),
	.port_link_traffic_led(port_link_traffic_led), .slave_state_led(slave_state_led), .error_led(error_led)
);

/* File: test/dsl_led_watch.sv */
`timescale 1ns/1ps
// ====
// operator eye: measures lit and dark runs of one led
module dsl_led_watch (
	input wire clk,
	input wire clr,
	input wire led,
	output reg [15:0] on_len,
	output reg [15:0] off_min,
	output reg [15:0] off_max
);
	reg prev; // level one cycle ago
	reg armed; // first run after clear is partial, so it is dropped
	reg [15:0] run; // cycles in the current level
	always @(posedge clk) begin
		prev <= led;
		if (clr) begin
			armed <= 1'b0;
			on_len <= 16'h0000;
			off_min <= 16'hffff;
			off_max <= 16'h0000;
		end else if (led !== prev) begin
			if (armed && prev) on_len <= run;
			if (armed && !prev && run < off_min) off_min <= run;
			if (armed && !prev && run > off_max) off_max <= run;
			armed <= 1'b1;
			run <= 16'h0001;
		end else begin
			run <= run + 16'h0001;
		end
	end
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
`include "dsl_defines.vh"
module tb;
	// ====
	// short ms so patterns fit the run: one ms is 5 cycles
	localparam int F = 1000;
	localparam int L = 5000;
	localparam int K = 250;
	reg clk, rstn, ls, dc, chg, bt, fw, pdi, cfg, awd, nwe, awv, wv, bre, arv, rre, clr;
	reg [1:0] lv, lt;
	reg [3:0] st;
	reg [15:0] nad;
	reg [11:0] awa, ara;
	reg [31:0] wd;
	wire awr, wr_, bv, arr, rv, gl, rl, ll, sl, el, irq;
	wire [1:0] bresp, rresp, pl;
	wire [31:0] rd_;
	wire [15:0] al, son, smin, smax, eon, emin, emax;
	int fails = 0;
	int checks_done = 0;
	int t;
	reg p;
	dsl_led_top #(.CYC_PER_MS(5), .NPORT(2)) DUT (.clk(clk), .rstn(rstn), .logic_supply_ok(ls),
		.dc_bus_ok(dc), .link_valid(lv), .link_traffic(lt), .al_state(st), .al_change(chg), .booting(bt),
		.fw_download(fw), .pdi_wd_timeout(pdi), .config_error(cfg), .app_wd_timeout(awd),
		.net_alias_data(nad), .net_alias_we(nwe), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
		.bridge_green_led(gl), .bridge_red_led(rl), .logic_supply_led(ll), .port_link_traffic_led(pl),
		.slave_state_led(sl), .error_led(el), .station_alias(al), .irq(irq));
	dsl_led_watch ws (.clk(clk), .clr(clr), .led(sl), .on_len(son), .off_min(smin), .off_max(smax));
	dsl_led_watch we (.clk(clk), .clr(clr), .led(el), .on_len(eon), .off_min(emin), .off_max(emax));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task chk(input string n, input [31:0] g, input [31:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task conclude;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one bus cycle; a read compares its data with d
	task automatic ax(input bit w, input [11:0] a, input [31:0] d, input [1:0] er);
		int n;
		@(posedge clk);
		{awv, wv, bre, arv, rre} <= {w, w, w, !w, !w};
		awa <= a;
		ara <= a;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awr) awv <= 0;
			if (wr_) wv <= 0;
			if (arr) arv <= 0;
		end while (!(w ? bv : rv) && n < 100);
		{bre, rre} <= 2'b00;
		chk("answer", w ? bv : rv, 1);
		chk("resp", w ? bresp : rresp, er);
		if (!w) chk("rdata", rd_, d);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// pattern on one led, measured after one partial period
	task pat(input bit e, input int on, input int lo, input int hi);
		wt(10);
		clr <= 1;
		wt(1);
		clr <= 0;
		wt(2 * (on + hi + (lo != hi ? on + lo : 0)) + 20);
		chk("on", e ? eon : son, on);
		chk("offmin", e ? emin : smin, lo);
		chk("offmax", e ? emax : smax, hi);
	endtask
	initial begin
		{rstn, ls, dc, chg, bt, fw, pdi, cfg, awd, nwe, awv, wv, bre, arv, rre, clr} = 0;
		{lv, lt, nad, awa, ara, wd} = 0;
		st = `DSL_ST_INIT;
		wt(3);
		rstn <= 1;
		wt(2);
		chk("irq", irq, 0);
		ax(0, `DSL_OFF_CTRL, 0, 0);
		ax(0, 12'h100, 0, 2);
		ax(1, 12'h100, 1, 2);
		ax(1, `DSL_OFF_ALIAS, 32'h0000_1234, 0);
		chk("alias", al, 16'h1234);
		nad <= 16'habcd;
		nwe <= 1;
		wt(3);
		nwe <= 0;
		wt(6);
		ax(0, `DSL_OFF_ALIAS, 32'h0000_abcd, 0);
		$display("test regs done");
		ls <= 1;
		dc <= 1;
		ax(1, `DSL_OFF_IRQ_MASK, 4, 0);
		ax(0, `DSL_OFF_IRQ_MASK, 4, 0);
		ax(1, `DSL_OFF_CTRL, 1, 0);
		wt(8);
		chk("bridge", {gl, rl, ll, irq}, 4'b1010);
		ax(1, `DSL_OFF_CTRL, 3, 0);
		wt(4);
		chk("fault", {gl, rl, irq}, 3'b011);
		ax(1, `DSL_OFF_IRQ_MASK, 0, 0);
		wt(3);
		chk("masked", irq, 0);
		ax(1, `DSL_OFF_IRQ_MASK, 4, 0);
		wt(3);
		chk("unmasked", irq, 1);
		ax(1, `DSL_OFF_IRQ_STAT, 4, 0);
		wt(3);
		chk("cleared", irq, 0);
		ax(1, `DSL_OFF_CTRL, 1, 0);
		{dc, ls} <= 2'b00;
		wt(8);
		chk("dark", {gl, rl, ll}, 0);
		$display("test bridge done");
		lv <= 3;
		wt(8);
		chk("link", pl, 3);
		lt <= 1;
		wt(10);
		t = 0;
		p = pl[0];
		repeat (1000) begin
			@(posedge clk);
			if (pl[0] !== p) t++;
			p = pl[0];
		end
		chk("toggles", t, 4);
		chk("steady", pl[1], 1);
		lv <= 0;
		wt(8);
		chk("nolink", pl, 0);
		$display("test link done");
		st <= `DSL_ST_PREOP;
		pat(0, F, F, F);
		st <= `DSL_ST_SAFEOP;
		pat(0, F, L, L);
		st <= `DSL_ST_BOOT;
		pat(0, K, K, K);
		st <= `DSL_ST_INIT;
		bt <= 1;
		pat(0, K, K, K);
		{bt, fw} <= 2'b01;
		st <= `DSL_ST_OP;
		pat(0, K, K, K);
		fw <= 0;
		wt(8);
		chk("op", sl, 1);
		$display("test state done");
		cfg <= 1;
		pat(1, F, F, F);
		awd <= 1;
		pat(1, F, F, L);
		{awd, cfg, chg} <= 3'b001;
		pat(1, F, L, L);
		st <= `DSL_ST_INIT;
		pat(1, K, K, K);
		wt(8);
		chk("init", sl, 0);
		pdi <= 1;
		wt(8);
		chk("pdi", el, 1);
		{pdi, chg} <= 2'b00;
		wt(8);
		chk("noerr", el, 0);
		ax(0, `DSL_OFF_IRQ_STAT, 32'h0000_0003, 0);
		ax(0, `DSL_OFF_STATUS, 32'h0000_0001, 0);
		$display("test error done");
		conclude;
	end
	// a hang ends the run as a mismatch
	initial begin
		wt(80000);
		fails++;
		$display("[FAIL] watchdog exp done got hang");
		conclude;
	end
endmodule
